// File: decode_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module decode_chk (
  // Clock, reset and core inputs
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_word_valid,
  input wire logic [decode_pkg::WORD_W-1:0] i_word,
  input wire decode_pkg::class_t i_class,
  input wire logic i_cond_true,
  input wire logic i_skip_over_double,
  input wire logic i_program_space_window,
  // Observed outputs
  input wire logic o_fetch_ready,
  input wire logic [15:0] o_pc,
  input wire logic o_instr_done,
  input wire logic o_second_word_error,
  input wire logic [15:0] o_file_addr,
  input wire logic [22:0] o_unsigned_23_bit_literal,
  input wire logic [9:0] o_unsigned_ten_bit_literal,
  input wire logic o_literal_ok,
  input wire logic [3:0] o_accum_writeback_dest,
  input wire logic o_writeback_post_inc,
  input wire logic [15:0] o_writeback_inc,
  input wire decode_pkg::size_t o_size,
  input wire logic [15:0] o_signed_ten_bit_literal,
  input wire logic [47:0] o_double_instr,
  input wire logic o_accum_b_clamped
);
  import decode_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic take;
  assign take = i_word_valid && o_fetch_ready;
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_take(class_t c);
    take && i_class == c;
  endsequence
  sequence s_pair;
    s_take(CLS_DOUBLE) ##1 take;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_pc_hold:
    assert property (!o_fetch_ready |=> o_pc == $past(o_pc)) else $error("pc moved while stalled");
  a_pc_step:
    assert property (take |=> o_pc == $past(o_pc) + PC_STEP) else $error("pc step wrong");
  a_skip_three:
    assert property (s_take(CLS_SKIP) ##0 (i_cond_true && i_skip_over_double)
      |=> !o_fetch_ready [*2] ##1 o_instr_done) else $error("skip over double not three cycles");
  a_table_two:
    assert property (s_take(CLS_TABLE) |=> !o_fetch_ready ##1 o_instr_done)
      else $error("table read not two cycles");
  a_simple_one:
    assert property (s_take(CLS_SIMPLE) ##0 (!i_program_space_window && i_word[23:16] != 8'h00)
      |=> o_instr_done && o_fetch_ready) else $error("simple word not one cycle");
  a_pair_join:
    assert property (s_pair |=> o_instr_done && o_double_instr == {$past(i_word, 2), $past(i_word)})
      else $error("double word not joined");
  a_second_tag:
    assert property (s_pair ##0 i_word[23:16] != SECOND_WORD_TAG |=> o_second_word_error)
      else $error("bad second word not flagged");
  a_lit_even:
    assert property (o_unsigned_23_bit_literal[0] == 1'b0) else $error("literal not even");
  a_file_range:
    assert property (o_file_addr <= FILE_ADDR_MAX) else $error("file address out of range");
  a_lit_limit:
    assert property (o_instr_done |-> o_literal_ok == (o_size != SIZE_BYTE
      || o_unsigned_ten_bit_literal <= BYTE_LIT_MAX)) else $error("literal limit wrong");
  a_writeback_dest:
    assert property (o_instr_done |-> o_accum_writeback_dest == WRITEBACK_REG
      && o_writeback_inc == (o_writeback_post_inc ? WRITEBACK_POST_INC : 16'h0000))
      else $error("write-back wrong");
  a_sign_ext:
    assert property (o_instr_done |-> o_signed_ten_bit_literal
      == {{6{o_unsigned_ten_bit_literal[9]}}, o_unsigned_ten_bit_literal}) else $error("sext wrong");
  a_clamp_keep:
    assert property (o_accum_b_clamped |=> o_accum_b_clamped) else $error("clamp flag dropped");
endmodule : decode_chk
bind instr_decoder decode_chk u_chk (.i_clock, .i_rst_n, .i_word_valid, .i_word, .i_class,
  .i_cond_true, .i_skip_over_double, .i_program_space_window, .o_fetch_ready, .o_pc,
  .o_instr_done, .o_second_word_error, .o_file_addr, .o_unsigned_23_bit_literal,
  .o_unsigned_ten_bit_literal, .o_literal_ok, .o_accum_writeback_dest, .o_writeback_post_inc,
  .o_writeback_inc, .o_size, .o_signed_ten_bit_literal, .o_double_instr, .o_accum_b_clamped);
`default_nettype wire

// File: decode_pkg.sv
// Functional notes
// - Double-word instruction carries 48 bits; second word's top 8 bits are zero.
// - A second word executed alone performs no operation.
// - Any double-word instruction takes two instruction cycles.
// - Single-word takes one cycle; true test, PC change, window or table read add NOP cycles.
// - Taken skip uses two cycles over one word, three over two words.
// - Double-word data moves take two instruction cycles.
// - File register address decodes over zero through 0x1FFF.
// - 23-bit unsigned literal has LSB zero and is read as even.
// - Ten-bit unsigned literal limited to 255 in byte size, 1023 in word size.
// - Bit position field is four bits selecting bit 0 to 15.
// - Base working register selects one of sixteen registers, 0 to 15.
// - Accumulator operand selects exactly one of A or B.
// - Write-back destination is W13 direct or [W13] with post-increment by 2.
// - Size suffix selects byte, word or double; word is default; shadow suffix separate.
// - Arithmetic keeps carry, digit carry, negative, range-exceeded and sticky zero flags.
// - DSP keeps range-exceeded and clamped flags for each accumulator.
// - Signed literals are two's complement: ten-bit -512..511, sixteen-bit -32768..32767.
package decode_pkg;
  localparam int WORD_W = 24;
  localparam int DATA_W = 16;
  localparam logic [7:0] SECOND_WORD_TAG = 8'h00;
  localparam logic [15:0] FILE_ADDR_MAX = 16'h1FFF;
  localparam logic [9:0] BYTE_LIT_MAX = 10'h0FF;
  localparam logic [9:0] WORD_LIT_MAX = 10'h3FF;
  localparam logic [3:0] WRITEBACK_REG = 4'hD;
  localparam logic [15:0] WRITEBACK_POST_INC = 16'h0002;
  localparam logic [1:0] CYCLES_ONE = 2'h1;
  localparam logic [1:0] CYCLES_TWO = 2'h2;
  localparam logic [1:0] CYCLES_THREE = 2'h3;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0002;
  // Operand size selection
  typedef enum logic [1:0] {
    SIZE_WORD = 2'b00,
    SIZE_BYTE = 2'b01,
    SIZE_DOUBLE = 2'b10
  } size_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_EXTRA = 2'b01,
    ST_SECOND = 2'b10
  } seq_state_t;
  // Instruction class as presented by the opcode decoder
  typedef enum logic [2:0] {
    CLS_SIMPLE = 3'b000,
    CLS_DOUBLE = 3'b001,
    CLS_SKIP = 3'b010,
    CLS_BRANCH = 3'b011,
    CLS_TABLE = 3'b100,
    CLS_DMOVE = 3'b101,
    CLS_ARITH = 3'b110,
    CLS_DSP = 3'b111
  } class_t;
endpackage : decode_pkg

// File: instr_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module instr_decoder (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Program memory word
  input wire logic i_word_valid,
  input wire logic [decode_pkg::WORD_W-1:0] i_word,
  // Instruction class and conditions
  input wire decode_pkg::class_t i_class,
  input wire logic i_cond_true,
  input wire logic i_skip_over_double,
  input wire logic i_program_space_window,
  // Operand fields
  input wire logic [1:0] i_size_suffix,
  input wire logic i_shadow_suffix,
  input wire logic i_writeback_indirect,
  input wire logic i_acc_sel,
  input wire logic i_zero_sticky,
  // Flag results from the datapath
  input wire logic i_carry,
  input wire logic i_digit_carry,
  input wire logic i_negative,
  input wire logic i_range,
  input wire logic i_zero,
  input wire logic i_acc_range,
  input wire logic i_acc_clamp,
  // Sequencing
  output logic o_fetch_ready,
  output logic [15:0] o_pc,
  output logic o_nop_cycle,
  output logic o_instr_done,
  output logic o_second_word_error,
  // Decoded operands
  output logic [15:0] o_file_addr,
  output logic o_file_addr_ok,
  output logic [22:0] o_unsigned_23_bit_literal,
  output logic [9:0] o_unsigned_ten_bit_literal,
  output logic o_literal_ok,
  output logic [3:0] o_bit_position_field,
  output logic [3:0] o_base_working_register,
  output logic o_accum_sel,
  output logic [3:0] o_accum_writeback_dest,
  output logic o_writeback_post_inc,
  output logic [15:0] o_writeback_inc,
  output decode_pkg::size_t o_size,
  output logic o_shadow_sel,
  output logic [15:0] o_signed_ten_bit_literal,
  output logic [15:0] o_signed_16_bit_literal,
  output logic [47:0] o_double_instr,
  // Status flags
  output logic o_carry_flag,
  output logic o_digit_carry_flag,
  output logic o_negative_flag,
  output logic o_signed_range_exceeded_flag,
  output logic o_zero_flag,
  output logic o_accum_a_range_exceeded,
  output logic o_accum_b_range_exceeded,
  output logic o_accum_a_clamped,
  output logic o_accum_b_clamped
);
  import decode_pkg::*;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [1:0] cycles_for(input class_t cls, input logic cond,
                                            input logic skip_dbl, input logic win);
    logic [1:0] n;
    n = CYCLES_ONE;
    case (cls)
      CLS_DOUBLE: n = CYCLES_TWO;
      CLS_DMOVE: n = CYCLES_TWO;
      CLS_BRANCH: n = cond ? CYCLES_TWO : CYCLES_ONE;
      CLS_TABLE: n = CYCLES_TWO;
      CLS_SKIP: n = cond ? (skip_dbl ? CYCLES_THREE : CYCLES_TWO) : CYCLES_ONE;
      default: n = win ? CYCLES_TWO : CYCLES_ONE;
    endcase
    return n;
  endfunction : cycles_for

  function automatic logic [15:0] sext10(input logic [9:0] v);
    return {{6{v[9]}}, v};
  endfunction : sext10

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  logic [1:0] remain;
  logic [1:0] next_remain;
  logic [1:0] need;
  logic take;
  logic first_dbl;

  assign o_fetch_ready = (state != ST_EXTRA);
  assign need = cycles_for(i_class, i_cond_true, i_skip_over_double, i_program_space_window);
  assign take = i_word_valid && (state == ST_FETCH);
  assign first_dbl = (i_class == CLS_DOUBLE) || (i_class == CLS_DMOVE);

  always_comb begin
    next_state = state;
    next_remain = remain;
    case (state)
      ST_FETCH: begin
        if (take && first_dbl) begin
          next_state = ST_SECOND;
          next_remain = 2'h0;
        end else if (take && need != CYCLES_ONE) begin
          next_state = ST_EXTRA;
          next_remain = need - CYCLES_ONE;
        end
      end
      ST_SECOND: begin
        if (i_word_valid) begin
          next_state = ST_FETCH;
        end
      end
      ST_EXTRA: begin
        next_remain = remain - 2'h1;
        if (remain == 2'h1) begin
          next_state = ST_FETCH;
        end
      end
      default: next_state = ST_FETCH;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_FETCH;
      remain <= 2'h0;
    end else begin
      state <= next_state;
      remain <= next_remain;
    end
  end

  // Program counter holds during extra cycles
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc <= PC_RESET;
    end else if (i_word_valid && state != ST_EXTRA) begin
      o_pc <= o_pc + PC_STEP;
    end
  end

  // Cycle markers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nop_cycle <= 1'b0;
      o_instr_done <= 1'b0;
      o_second_word_error <= 1'b0;
    end else begin
      o_nop_cycle <= (state == ST_EXTRA);
      o_instr_done <= (take && next_state == ST_FETCH) ||
                      (state == ST_EXTRA && remain == 2'h1) ||
                      (state == ST_SECOND && i_word_valid);
      o_second_word_error <= (state == ST_SECOND) && i_word_valid &&
                             (i_word[23:16] != SECOND_WORD_TAG);
    end
  end

  // ----------------------------------------
  // Double-word capture
  // ----------------------------------------
  logic [WORD_W-1:0] first_word;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_word <= '0;
      o_double_instr <= '0;
    end else if (take && first_dbl) begin
      first_word <= i_word;
    end else if (state == ST_SECOND && i_word_valid) begin
      o_double_instr <= {first_word, i_word};
    end
  end

  // ----------------------------------------
  // Operand decode
  // ----------------------------------------
  logic lone_second;
  logic op_load;
  size_t size_sel;
  logic [9:0] ten_lit;

  // A stray second word on its own decodes as a no-op
  assign lone_second = (i_class == CLS_SIMPLE) && (i_word[23:16] == SECOND_WORD_TAG);
  assign op_load = take && !lone_second;
  assign size_sel = (i_size_suffix == 2'b01) ? SIZE_BYTE :
                    (i_size_suffix == 2'b10) ? SIZE_DOUBLE : SIZE_WORD;
  assign ten_lit = i_word[13:4];

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_file_addr <= '0;
      o_file_addr_ok <= 1'b0;
      o_unsigned_23_bit_literal <= '0;
      o_unsigned_ten_bit_literal <= '0;
      o_literal_ok <= 1'b0;
      o_bit_position_field <= '0;
      o_base_working_register <= '0;
      o_accum_sel <= 1'b0;
      o_accum_writeback_dest <= '0;
      o_writeback_post_inc <= 1'b0;
      o_writeback_inc <= '0;
      o_size <= SIZE_WORD;
      o_shadow_sel <= 1'b0;
      o_signed_ten_bit_literal <= '0;
      o_signed_16_bit_literal <= '0;
    end else if (op_load) begin
      o_file_addr <= {3'h0, i_word[13:1]};
      o_file_addr_ok <= ({3'h0, i_word[13:1]} <= FILE_ADDR_MAX);
      o_unsigned_23_bit_literal <= {i_word[22:1], 1'b0};
      o_unsigned_ten_bit_literal <= ten_lit;
      o_literal_ok <= (size_sel == SIZE_BYTE) ? (ten_lit <= BYTE_LIT_MAX)
                                              : (ten_lit <= WORD_LIT_MAX);
      o_bit_position_field <= i_word[15:12];
      o_base_working_register <= i_word[3:0];
      o_accum_sel <= i_acc_sel;
      o_accum_writeback_dest <= WRITEBACK_REG;
      o_writeback_post_inc <= i_writeback_indirect;
      o_writeback_inc <= i_writeback_indirect ? WRITEBACK_POST_INC : 16'h0000;
      o_size <= size_sel;
      o_shadow_sel <= i_shadow_suffix;
      o_signed_ten_bit_literal <= sext10(ten_lit);
      o_signed_16_bit_literal <= i_word[19:4];
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  status_flags u_flags (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_arith_upd(op_load && i_class == CLS_ARITH),
    .i_zero_sticky(i_zero_sticky),
    .i_dsp_upd(op_load && i_class == CLS_DSP),
    .i_acc_sel(i_acc_sel),
    .i_carry(i_carry),
    .i_digit_carry(i_digit_carry),
    .i_negative(i_negative),
    .i_range(i_range),
    .i_zero(i_zero),
    .i_acc_range(i_acc_range),
    .i_acc_clamp(i_acc_clamp),
    .o_carry_flag(o_carry_flag),
    .o_digit_carry_flag(o_digit_carry_flag),
    .o_negative_flag(o_negative_flag),
    .o_signed_range_exceeded_flag(o_signed_range_exceeded_flag),
    .o_zero_flag(o_zero_flag),
    .o_accum_a_range_exceeded(o_accum_a_range_exceeded),
    .o_accum_b_range_exceeded(o_accum_b_range_exceeded),
    .o_accum_a_clamped(o_accum_a_clamped),
    .o_accum_b_clamped(o_accum_b_clamped)
  );
endmodule : instr_decoder
`default_nettype wire

// File: prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module prog_mem (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Request
  input wire logic i_start,
  input wire logic i_two,
  input wire logic [23:0] i_first,
  input wire logic [23:0] i_second,
  input wire logic i_fetch_ready,
  // Program word
  output logic o_word_valid,
  output logic [23:0] o_word
);
  logic left;
  // Word held until taken; a released bus shows the inverse of the last word
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left <= 1'b0;
      o_word_valid <= 1'b0;
      o_word <= 24'h00_0000;
    end else if (i_start) begin
      o_word_valid <= 1'b1;
      o_word <= i_first;
      left <= i_two;
    end else if (o_word_valid && i_fetch_ready) begin
      if (left) begin
        o_word <= i_second;
        left <= 1'b0;
      end else begin
        o_word_valid <= 1'b0;
        o_word <= ~o_word;
      end
    end
  end
endmodule : prog_mem
`default_nettype wire

// File: status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module status_flags (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Update strobes
  input wire logic i_arith_upd,
  input wire logic i_zero_sticky,
  input wire logic i_dsp_upd,
  input wire logic i_acc_sel,
  // Flag inputs
  input wire logic i_carry,
  input wire logic i_digit_carry,
  input wire logic i_negative,
  input wire logic i_range,
  input wire logic i_zero,
  input wire logic i_acc_range,
  input wire logic i_acc_clamp,
  // Flag outputs
  output logic o_carry_flag,
  output logic o_digit_carry_flag,
  output logic o_negative_flag,
  output logic o_signed_range_exceeded_flag,
  output logic o_zero_flag,
  output logic o_accum_a_range_exceeded,
  output logic o_accum_b_range_exceeded,
  output logic o_accum_a_clamped,
  output logic o_accum_b_clamped
);
  // ----------------------------------------
  // Arithmetic flags
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_carry_flag <= 1'b0;
      o_digit_carry_flag <= 1'b0;
      o_negative_flag <= 1'b0;
      o_signed_range_exceeded_flag <= 1'b0;
    end else if (i_arith_upd) begin
      o_carry_flag <= i_carry;
      o_digit_carry_flag <= i_digit_carry;
      o_negative_flag <= i_negative;
      o_signed_range_exceeded_flag <= i_range;
    end
  end

  // Sticky zero: with sticky mode a nonzero result clears, zero result keeps
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_zero_flag <= 1'b0;
    end else if (i_arith_upd) begin
      o_zero_flag <= i_zero_sticky ? (o_zero_flag & i_zero) : i_zero;
    end
  end

  // ----------------------------------------
  // DSP accumulator flags
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accum_a_range_exceeded <= 1'b0;
      o_accum_b_range_exceeded <= 1'b0;
      o_accum_a_clamped <= 1'b0;
      o_accum_b_clamped <= 1'b0;
    end else if (i_dsp_upd) begin
      if (!i_acc_sel) begin
        o_accum_a_range_exceeded <= i_acc_range;
        o_accum_a_clamped <= i_acc_clamp | o_accum_a_clamped;
      end else begin
        o_accum_b_range_exceeded <= i_acc_range;
        o_accum_b_clamped <= i_acc_clamp | o_accum_b_clamped;
      end
    end
  end
endmodule : status_flags
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import decode_pkg::*;
  logic i_clock = 1'b0, i_rst_n = 1'b0, start = 1'b0, two = 1'b0, err_seen;
  logic [23:0] first = 24'h00_0000, second = 24'h00_0000, i_word;
  class_t i_class = CLS_SIMPLE;
  logic i_cond_true = 1'b0, i_skip_over_double = 1'b0, i_program_space_window = 1'b0;
  logic [1:0] i_size_suffix = 2'h0;
  logic i_shadow_suffix = 1'b0, i_writeback_indirect = 1'b0;
  logic i_acc_sel = 1'b0, i_zero_sticky = 1'b0;
  logic i_carry = 1'b0, i_digit_carry = 1'b0, i_negative = 1'b0, i_range = 1'b0, i_zero = 1'b0;
  logic i_acc_range = 1'b0, i_acc_clamp = 1'b0, i_word_valid, o_fetch_ready, o_instr_done;
  logic o_second_word_error, o_literal_ok, o_accum_sel, o_writeback_post_inc, o_shadow_sel;
  logic o_nop_cycle, o_file_addr_ok;
  logic o_carry_flag, o_digit_carry_flag, o_negative_flag, o_signed_range_exceeded_flag;
  logic o_zero_flag, o_accum_a_range_exceeded, o_accum_b_range_exceeded;
  logic o_accum_a_clamped, o_accum_b_clamped;
  logic [15:0] o_pc, o_file_addr, o_writeback_inc;
  logic [15:0] o_signed_ten_bit_literal, o_signed_16_bit_literal;
  logic [22:0] o_unsigned_23_bit_literal;
  logic [9:0] o_unsigned_ten_bit_literal;
  logic [3:0] o_bit_position_field, o_base_working_register, o_accum_writeback_dest;
  logic [47:0] o_double_instr;
  size_t o_size;
  int failures = 0;
  int checked = 0;
  logic [7:0] tbl [10] = '{8'h01, 8'h06, 8'h41, 8'h52, 8'h5B, 8'h72, 8'h61, 8'h82, 8'hC6, 8'hE1};
  always #10 i_clock = ~i_clock;
  prog_mem u_mem (.i_clock, .i_rst_n, .i_start(start), .i_two(two), .i_first(first),
    .i_second(second), .i_fetch_ready(o_fetch_ready), .o_word_valid(i_word_valid),
    .o_word(i_word));
  instr_decoder DUT (.*);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic run(input class_t c, input logic [23:0] w1, input logic [23:0] w2,
                     input logic dw, input int need);
    logic [15:0] pc0;
    int n;
    int nops;
    pc0 = o_pc;
    i_class = c;
    first = w1;
    second = w2;
    two = dw;
    start = 1'b1;
    @(negedge i_clock);
    start = 1'b0;
    n = 0;
    nops = 0;
    err_seen = 1'b0;
    do begin
      @(negedge i_clock);
      n++;
      err_seen |= o_second_word_error;
      if (o_nop_cycle === 1'b1) nops++;
    end while (o_instr_done !== 1'b1 && n < 20);
    check("cycles", n, need);
    check("nop cycles", nops, dw ? 0 : need - 1);
    check("pc", o_pc, pc0 + (dw ? 16'h0004 : 16'h0002));
    if (n >= 20) final_report();
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_timing;
    foreach (tbl[k]) begin
      i_cond_true = tbl[k][4];
      i_skip_over_double = tbl[k][3];
      i_program_space_window = tbl[k][2];
      run(class_t'(tbl[k][7:5]), 24'h81_2345, 24'h00_0000, 1'b0, int'(tbl[k][1:0]));
    end
    i_cond_true = 1'b0;
    i_skip_over_double = 1'b0;
    i_program_space_window = 1'b0;
  endtask : t_timing
  task automatic t_double;
    run(CLS_DOUBLE, 24'h95_1234, 24'h00_ABCD, 1'b1, 2);
    check("joined", o_double_instr, 48'h95_1234_00AB_CD);
    check("tag err", err_seen, 1'b0);
    run(CLS_DMOVE, 24'h96_0001, 24'h00_0002, 1'b1, 2);
    run(CLS_DOUBLE, 24'h95_1234, 24'h3C_0001, 1'b1, 2);
    check("tag err", err_seen, 1'b1);
  endtask : t_double
  task automatic t_operands;
    i_size_suffix = 2'h1;
    i_shadow_suffix = 1'b1;
    i_writeback_indirect = 1'b1;
    i_acc_sel = 1'b1;
    run(CLS_SIMPLE, 24'h9A_BCDF, 24'h00_0000, 1'b0, 1);
    check("file", {o_file_addr, o_file_addr_ok}, {16'h1E6F, 1'b1});
    check("even lit", o_unsigned_23_bit_literal, 23'h1A_BCDE);
    check("lit ok", o_literal_ok, 1'b0);
    check("bit", o_bit_position_field, 4'hB);
    check("base", o_base_working_register, 4'hF);
    check("acc", o_accum_sel, 1'b1);
    check("writeback", {o_accum_writeback_dest, o_writeback_post_inc, o_writeback_inc},
      21'h1B_0002);
    check("size", {o_size, o_shadow_sel}, {SIZE_BYTE, 1'b1});
    check("s10", {o_signed_ten_bit_literal, o_signed_16_bit_literal}, 32'hFFCD_ABCD);
    i_size_suffix = 2'h0;
    run(CLS_SIMPLE, 24'h9A_BCDF, 24'h00_0000, 1'b0, 1);
    check("lit ok", {o_size, o_literal_ok}, {SIZE_WORD, 1'b1});
    i_size_suffix = 2'h2;
    run(CLS_SIMPLE, 24'h00_0042, 24'h00_0000, 1'b0, 1);
    check("lone", {o_file_addr, o_size}, {16'h1E6F, SIZE_WORD});
    run(CLS_SIMPLE, 24'h9A_BCDF, 24'h00_0000, 1'b0, 1);
    check("size", o_size, SIZE_DOUBLE);
  endtask : t_operands
  task automatic t_flags;
    {i_carry, i_digit_carry, i_negative, i_range, i_zero} = 5'h1F;
    run(CLS_ARITH, 24'h81_0000, 24'h00_0000, 1'b0, 1);
    check("flags", {o_carry_flag, o_digit_carry_flag, o_negative_flag,
      o_signed_range_exceeded_flag, o_zero_flag}, 5'h1F);
    i_zero_sticky = 1'b1;
    {i_carry, i_zero} = 2'h0;
    run(CLS_ARITH, 24'h81_0000, 24'h00_0000, 1'b0, 1);
    check("zero", {o_carry_flag, o_zero_flag}, 2'h0);
    i_zero = 1'b1;
    run(CLS_ARITH, 24'h81_0000, 24'h00_0000, 1'b0, 1);
    check("sticky", o_zero_flag, 1'b0);
    {i_acc_range, i_acc_clamp} = 2'h3;
    run(CLS_DSP, 24'h81_0000, 24'h00_0000, 1'b0, 1);
    check("dsp", {o_accum_a_range_exceeded, o_accum_b_range_exceeded, o_accum_a_clamped,
      o_accum_b_clamped}, 4'h5);
    {i_acc_range, i_acc_clamp} = 2'h0;
    run(CLS_DSP, 24'h81_0000, 24'h00_0000, 1'b0, 1);
    check("clamp", {o_accum_b_range_exceeded, o_accum_b_clamped}, 2'h1);
  endtask : t_flags
  initial begin
    repeat (6) @(negedge i_clock);
    i_rst_n = 1'b1;
    check("reset", {o_pc, o_fetch_ready, o_size}, {16'h0000, 1'b1, SIZE_WORD});
    t_timing();
    t_double();
    t_operands();
    t_flags();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
